// ---- pct_timer.sv ----
`timescale 1ns/100ps

// Summary of operation
// - one-shot: output low for n time-base periods, n the selected count
// - idle output high; trigger drives output low and starts a cycle
// - tick source runs and counter advances until programmed count reached
// - one-shot: count reached raises output, stops ticks, clears counter, idles
// - timer output derived from the selected, joined counter taps
// - astable: end of count never resets; oscillation continues after trigger
// - astable single tap of weight n toggles every n periods
// - astable self-starts after reset if trigger is already high; otherwise waits for a trigger
// - reset pulse stops oscillation, output high until next trigger
// - triggers ignored while running; trigger beats simultaneous reset
// - power-up enters reset: TIMER_OUT and COUNTER_OUT high, BUSY low, tick source disabled
// - joined taps sum their weights, giving counts 1 to 255
// - trigger and reset act on rising edges only
module pct_timer
  import pct_pkg::*;
#(
  parameter int unsigned TICK_DIV = TB_CYCLES
) (
  input  wire logic       CLK,             // system clock
  input  wire logic       RESET,           // synchronous reset, active high
  input  wire logic       CE,              // clock enable, freezes state when low
  input  wire logic       TRIGGER,         // start input, rising edge
  input  wire logic       RESET_IN,        // stop input, rising edge
  input  wire logic       MODE,            // 0 one-shot, 1 astable
  input  wire logic [7:0] TAP_SEL,         // joined counter taps
  output logic            TIMER_OUT,       // combined timer output
  output logic [7:0]      COUNTER_OUT,     // individual tap levels
  output logic            TIME_BASE_TICK,  // time-base tick pulse
  output logic            BUSY             // timing cycle active
);

  // refuse dividers the time base cannot serve
  if (TICK_DIV < 1 || TICK_DIV > (2 ** TB_CNT_WIDTH)) begin : g_div_check
    $error("pct_timer: TICK_DIV out of range");
  end

  typedef struct packed {
    pct_state_e state;
    logic [7:0] cnt;
    logic       trig_q;
    logic       rst_q;
    logic       out;
  } pct_timer_s;

  pct_timer_s s;
  pct_timer_s next_s;
  logic       tick;
  logic       trig_edge;
  logic       rst_edge;

  pct_tick_gen #(
    .DIV                (TICK_DIV)
  ) u_tick (
    .CLK                (CLK),
    .RESET              (RESET),
    .CE                 (CE),
    .ENABLE             (s.state == PCT_RUN),
    .TIME_BASE_TICK_OUT (tick)
  );

  assign trig_edge = TRIGGER & ~s.trig_q;
  assign rst_edge  = RESET_IN & ~s.rst_q;

  always_comb begin
    next_s        = s;
    next_s.trig_q = TRIGGER;
    next_s.rst_q  = RESET_IN;
    unique case (s.state)
      PCT_IDLE: begin
        if (trig_edge) begin
          next_s.state = PCT_RUN;
          next_s.cnt   = CNT_RESET;
        end
      end
      PCT_RUN: begin
        if (rst_edge && trig_edge) begin
          next_s.cnt   = CNT_RESET;
        end else if (rst_edge) begin
          next_s.state = PCT_IDLE;
          next_s.cnt   = CNT_RESET;
        end else if (tick) begin
          next_s.cnt   = s.cnt + 8'h01;
        end
      end
    endcase
    next_s.out = pct_tap_out(next_s.state == PCT_RUN, next_s.cnt, TAP_SEL);
    if (MODE == MODE_ONE_SHOT && next_s.state == PCT_RUN && next_s.out) begin
      next_s.state = PCT_IDLE;
      next_s.cnt   = CNT_RESET;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s.state  <= PCT_IDLE;
      s.cnt    <= CNT_RESET;
      s.trig_q <= 1'b0;
      s.rst_q  <= 1'b0;
      s.out    <= OUT_IDLE;
    end else if (CE) begin
      s <= next_s;
    end
  end

  assign TIMER_OUT      = s.out;
  assign COUNTER_OUT    = (s.state == PCT_RUN) ? s.cnt : 8'hff;
  assign TIME_BASE_TICK = tick;
  assign BUSY           = (s.state == PCT_RUN);

endmodule // pct_timer

// ---- pct_pkg.sv ----
package pct_pkg;

  // counter geometry
  localparam int unsigned CNT_WIDTH     = 8;
  localparam int unsigned CNT_MAX       = 255;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  // fastest recommended time base: 100 kHz, i.e. a 10 us period
  localparam int unsigned TB_MAX_KHZ    = 100;
  localparam int unsigned TB_PERIOD_NS  = 1_000_000 / TB_MAX_KHZ;
  localparam int unsigned TB_CYCLES     = TB_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TB_CNT_WIDTH  = 16;

  // mode select encoding
  localparam logic        MODE_ONE_SHOT = 1'b0;
  localparam logic        MODE_ASTABLE  = 1'b1;

  // reset values
  localparam logic        OUT_IDLE      = 1'b1;
  localparam logic [7:0]  CNT_RESET     = 8'h00;

  typedef enum logic {
    PCT_IDLE,
    PCT_RUN
  } pct_state_e;

  // timer output from the selected taps: a tap pin is high while idle or
  // while its counter bit is set; the joined bus is high only when every
  // selected pin is high, so the first count that lights all of them is
  // the sum of their weights
  function automatic logic pct_tap_out(input logic       running,
                                       input logic [7:0] cnt,
                                       input logic [7:0] sel);
    logic [7:0] pins;
    pins        = running ? cnt : 8'hff;
    pct_tap_out = &(pins | ~sel);
  endfunction

endpackage : pct_pkg

// ---- pct_tick_gen.sv ----
`timescale 1ns/100ps

// time-base tick source: one-cycle pulse every DIV cycles while enabled
module pct_tick_gen
  import pct_pkg::*;
#(
  parameter int unsigned DIV = TB_CYCLES
) (
  input  wire logic CLK,                    // system clock
  input  wire logic RESET,                  // synchronous reset, active high
  input  wire logic CE,                     // clock enable
  input  wire logic ENABLE,                 // run the time base
  output logic      TIME_BASE_TICK_OUT      // tick pulse
);

  // refuse dividers the counter cannot hold
  if (DIV < 1 || DIV > (2 ** TB_CNT_WIDTH)) begin : g_div_check
    $error("pct_tick_gen: DIV out of range");
  end

  localparam logic [TB_CNT_WIDTH-1:0] DIV_LAST = TB_CNT_WIDTH'(DIV - 1);

  typedef struct packed {
    logic [TB_CNT_WIDTH-1:0] div_cnt;
    logic                    tick;
  } pct_tick_s;

  pct_tick_s s;
  pct_tick_s next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!ENABLE) begin
      next_s.div_cnt = '0;
    end else if (s.div_cnt == DIV_LAST) begin
      next_s.div_cnt = '0;
      next_s.tick    = 1'b1;
    end else begin
      next_s.div_cnt = s.div_cnt + TB_CNT_WIDTH'(1);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s <= '0;
    end else if (CE) begin
      s <= next_s;
    end
  end

  assign TIME_BASE_TICK_OUT = s.tick;

endmodule // pct_tick_gen

// ---- pct_checker.sv ----
`timescale 1ns/100ps
module pct_checker
  import pct_pkg::*;
#(
  parameter int unsigned TICK_DIV = TB_CYCLES
) (
  input wire logic       CLK,             // clock
  input wire logic       RESET,           // reset
  input wire logic       TRIGGER,         // start
  input wire logic       RESET_IN,        // stop
  input wire logic       MODE,            // mode
  input wire logic [7:0] TAP_SEL,         // taps
  input wire logic       TIMER_OUT,       // output
  input wire logic [7:0] COUNTER_OUT,     // tap levels
  input wire logic       TIME_BASE_TICK,  // tick
  input wire logic       BUSY             // running
);
  logic [15:0] gap;
  // cycles since start or last tick
  always_ff @(posedge CLK) begin
    gap <= TIME_BASE_TICK ? 16'h0001 : (RESET || !BUSY) ? 16'h0000 : gap + 16'h0001;
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  AST_IDLE: assert property (!BUSY |-> TIMER_OUT && COUNTER_OUT == 8'hff)
    else $error("idle levels");
  AST_START: assert property ($rose(TRIGGER) && !BUSY && TAP_SEL != 8'h00 |=> BUSY && !TIMER_OUT)
    else $error("no start");
  AST_GAP: assert property (TIME_BASE_TICK |-> gap == TICK_DIV)
    else $error("tick spacing");
  AST_STEP: assert property (BUSY && TIME_BASE_TICK && !$rose(RESET_IN)
    |=> !BUSY || COUNTER_OUT == $past(COUNTER_OUT) + 8'h01)
    else $error("count step");
  AST_OS_LOW: assert property (MODE == MODE_ONE_SHOT && BUSY && TAP_SEL != 8'h00 |-> !TIMER_OUT)
    else $error("one-shot level");
  AST_OS_END: assert property (MODE == MODE_ONE_SHOT && TIME_BASE_TICK
    && ((COUNTER_OUT + 8'h01) & TAP_SEL) == TAP_SEL |=> !BUSY && TIMER_OUT)
    else $error("one-shot end");
  AST_RUN: assert property (MODE == MODE_ASTABLE && BUSY && !$rose(RESET_IN) |=> BUSY)
    else $error("astable stopped");
  AST_STOP: assert property (BUSY && $rose(RESET_IN) && !$rose(TRIGGER) |=> !BUSY && TIMER_OUT)
    else $error("no stop");
  C_OS: cover property (MODE == MODE_ONE_SHOT && $fell(BUSY));
  C_AST: cover property (MODE == MODE_ASTABLE && BUSY && $rose(TIMER_OUT));
  C_STOP: cover property (MODE == MODE_ASTABLE && $fell(BUSY));
endmodule // pct_checker

bind pct_timer pct_checker #(.TICK_DIV(TICK_DIV)) u_pct_checker (.*);

// ---- pct_partner.sv ----
`timescale 1ns/100ps
module pct_partner (
  input  wire logic CLK,      // clock
  input  wire logic T_REQ,    // start request
  input  wire logic R_REQ,    // stop request
  output logic      TRIGGER,  // start line
  output logic      RESET_IN  // stop line
);
  initial TRIGGER = 1'b0;
  initial RESET_IN = 1'b0;
  // clean transitions only; a held request is the auto-start level
  always @(posedge CLK) begin
    TRIGGER  <= T_REQ;
    RESET_IN <= R_REQ;
  end
endmodule // pct_partner

// ---- programmable_counter_timer_tb_top.sv ----
`timescale 1ns/100ps
module programmable_counter_timer_tb_top
  import pct_pkg::*;
;
  // scaled time base for run length; the default divider keeps the tick rate ceiling
  localparam int unsigned D = 4;
  logic        CLK, RESET, t_req, r_req, mode, trg, rin, tout, busy, last;
  logic [7:0]  tap, cnt;
  logic [15:0] lo_len, hi_len;
  int          bad_count = 0, tests_run = 0, cyc = 0, stamp = 0;
  pct_partner u_pct_partner (.CLK(CLK), .T_REQ(t_req), .R_REQ(r_req), .TRIGGER(trg), .RESET_IN(rin));
  pct_timer #(.TICK_DIV(D)) u_pct_timer (.CLK(CLK), .RESET(RESET), .CE(1'b1), .TRIGGER(trg), .RESET_IN(rin),
    .MODE(mode), .TAP_SEL(tap), .TIMER_OUT(tout), .COUNTER_OUT(cnt), .TIME_BASE_TICK(), .BUSY(busy));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // output run lengths in cycles
  always @(posedge CLK) begin
    cyc++;
    if (tout !== last) begin
      if (tout === 1'b1) lo_len = 16'(cyc - stamp);
      else hi_len = 16'(cyc - stamp);
      stamp = cyc;
    end
    last = tout;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic pulse(input logic t, input logic r);
    @(posedge CLK);
    t_req <= t;
    r_req <= r;
    @(posedge CLK);
    t_req <= 1'b0;
    r_req <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(negedge CLK);
    repeat (1100) if (busy !== 1'b0) @(negedge CLK);
    repeat (2) @(negedge CLK);
  endtask
  task automatic t_idle();
    repeat (20) @(negedge CLK);
    chk("idle", {busy, tout, cnt}, 10'h1ff);
    $display("idle done");
  endtask
  task automatic t_oneshot();
    logic [7:0] taps [4] = '{8'h01, 8'h02, 8'h91, 8'hff};
    foreach (taps[i]) begin
      @(posedge CLK);
      mode <= MODE_ONE_SHOT;
      tap  <= taps[i];
      pulse(1'b1, 1'b0);
      @(negedge CLK);
      pulse(1'b1, 1'b0);
      settle();
      chk("low", lo_len, 16'(taps[i] * D + 1));
    end
    $display("one-shot done");
  endtask
  task automatic t_astable();
    @(posedge CLK);
    mode <= MODE_ASTABLE;
    tap  <= 8'h02;
    pulse(1'b1, 1'b1);
    repeat (44) @(negedge CLK);
    chk("low", lo_len, 16'(2 * D));
    chk("high", hi_len, 16'(2 * D));
    pulse(1'b1, 1'b1);
    repeat (3) @(negedge CLK);
    chk("restart", {busy, tout}, 2'b10);
    pulse(1'b0, 1'b1);
    repeat (20) @(negedge CLK);
    chk("stop", {busy, tout}, 2'b01);
    $display("astable done");
  endtask
  task automatic t_auto();
    @(posedge CLK);
    t_req <= 1'b1;
    RESET <= 1'b1;
    // trigger already high when reset lets go
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(negedge CLK);
    chk("auto", busy, 1'b1);
    $display("auto done");
  endtask
  initial begin
    RESET = 1'b1;
    t_req = 1'b0;
    r_req = 1'b0;
    mode  = MODE_ASTABLE;
    tap   = 8'h02;
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    t_idle();
    t_oneshot();
    t_astable();
    t_auto();
    results();
  end
endmodule // programmable_counter_timer_tb_top
